// [dv/sbs_ctrl_model.sv]
`timescale 1ns/1ns
module sbs_ctrl_model
   import sbs_pkg::*;
(
   // Clock
   input  wire logic       sys_clk_in,
   // Answers
   input  wire logic       rsp_valid_in,
   input  wire logic [7:0] rsp_data_in,
   input  wire logic       rsp_poll_in,
   // Requests
   output logic            cmd_valid_out,
   output logic [2:0]      cmd_code_out,
   output logic [7:0]      cmd_data_out,
   output logic            serial_poll_out
);
   initial begin
      cmd_valid_out   = 1'b0;
      cmd_code_out    = 3'h7;
      cmd_data_out    = 8'h00;
      serial_poll_out = 1'b0;
   end

   // Mask writes and queries; gap models a slow controller
   task automatic issue(input sbs_cmd_e c, input logic [7:0] d,
                        input int gap, output logic [9:0] ans);
      repeat (gap + 1) @(posedge sys_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_code_out  <= c;
      cmd_data_out  <= d;
      @(posedge sys_clk_in);
      cmd_valid_out <= 1'b0;
      // Stale data inverted so nothing leans on a held value
      cmd_data_out  <= ~d;
      #1;
      ans = {rsp_valid_in, rsp_poll_in, rsp_data_in};
   endtask

   // Write then query on the very next edge
   task automatic pair(input sbs_cmd_e w, input sbs_cmd_e q,
                       input logic [7:0] d, output logic [9:0] ans);
      @(posedge sys_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_code_out  <= w;
      cmd_data_out  <= d;
      @(posedge sys_clk_in);
      cmd_code_out  <= q;
      cmd_data_out  <= ~d;
      @(posedge sys_clk_in);
      cmd_valid_out <= 1'b0;
      #1;
      ans = {rsp_valid_in, rsp_poll_in, rsp_data_in};
   endtask

   // Poll and command together; the command must be lost
   task automatic collide(input sbs_cmd_e c, input logic [7:0] d,
                          output logic [9:0] ans);
      @(posedge sys_clk_in);
      cmd_valid_out   <= 1'b1;
      cmd_code_out    <= c;
      cmd_data_out    <= d;
      serial_poll_out <= 1'b1;
      @(posedge sys_clk_in);
      cmd_valid_out   <= 1'b0;
      serial_poll_out <= 1'b0;
      #1;
      ans = {rsp_valid_in, rsp_poll_in, rsp_data_in};
   endtask

   // One serial poll to answer a service request
   task automatic poll(output logic [9:0] ans);
      @(posedge sys_clk_in);
      serial_poll_out <= 1'b1;
      @(posedge sys_clk_in);
      serial_poll_out <= 1'b0;
      #1;
      ans = {rsp_valid_in, rsp_poll_in, rsp_data_in};
   endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import sbs_pkg::*;
   logic       sys_clk_in;
   logic       reset_in;
   logic [5:0] src;
   logic       cmd_valid;
   logic [2:0] cmd_code;
   logic [7:0] cmd_data;
   logic       serial_poll;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_poll;
   logic       srq;
   logic       ist;
   logic [7:0] status_byte;
   logic [9:0] ans;
   int         errors;
   int         checks_done;

   sbs_status_top u_sbs_status_top (
      .sys_clk_in                (sys_clk_in),
      .reset_in                  (reset_in),
      .err_nonempty_in           (src[0]),
      .err_entry_in              (src[1]),
      .ques_sum_in               (src[2]),
      .message_available_flag_in (src[3]),
      .event_summary_flag_in     (src[4]),
      .oper_sum_in               (src[5]),
      .cmd_valid_in              (cmd_valid),
      .cmd_code_in               (cmd_code),
      .cmd_data_in               (cmd_data),
      .serial_poll_in            (serial_poll),
      .rsp_valid_out             (rsp_valid),
      .rsp_data_out              (rsp_data),
      .rsp_poll_out              (rsp_poll),
      .srq_out                   (srq),
      .ist_out                   (ist),
      .summary_status_byte_out   (status_byte)
   );

   sbs_ctrl_model u_sbs_ctrl_model (
      .sys_clk_in      (sys_clk_in),
      .rsp_valid_in    (rsp_valid),
      .rsp_data_in     (rsp_data),
      .rsp_poll_in     (rsp_poll),
      .cmd_valid_out   (cmd_valid),
      .cmd_code_out    (cmd_code),
      .cmd_data_out    (cmd_data),
      .serial_poll_out (serial_poll)
   );

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [9:0] status();
      return {srq, ist, status_byte};
   endfunction

   task automatic drive(input logic [5:0] v);
      @(posedge sys_clk_in);
      src <= v;
   endtask

   task automatic settle();
      @(posedge sys_clk_in);
      #1;
   endtask

   task automatic cmd(input sbs_cmd_e c, input logic [7:0] d, input int gap);
      u_sbs_ctrl_model.issue(c, d, gap, ans);
   endtask

   task automatic t_reset();
      #1;
      chk(status(), 10'h000);
      cmd(CMD_SRQM_QUERY, 8'h00, 0);
      chk(ans, 10'h200);
      cmd(CMD_PRE_QUERY, 8'h00, 0);
      chk(ans, 10'h200);
      // Write beside a poll is dropped, spare code gives no answer
      u_sbs_ctrl_model.collide(CMD_SRQM_WRITE, 8'hFF, ans);
      chk(ans, 10'h300);
      cmd(CMD_SRQM_QUERY, 8'h00, 0);
      chk(ans, 10'h200);
      cmd(sbs_cmd_e'(3'h6), 8'hFF, 0);
      chk(ans, 10'h000);
      $display("t_reset done");
   endtask

   task automatic t_masks();
      cmd(CMD_SRQM_WRITE, 8'hA5, 0);
      cmd(CMD_SRQM_QUERY, 8'h00, 0);
      chk(ans, 10'h2A5);
      cmd(CMD_PRE_WRITE, 8'h5A, 0);
      cmd(CMD_PRE_QUERY, 8'h00, 3);
      chk(ans, 10'h25A);
      u_sbs_ctrl_model.pair(CMD_SRQM_WRITE, CMD_SRQM_QUERY, 8'hC3, ans);
      chk(ans, 10'h2C3);
      u_sbs_ctrl_model.pair(CMD_PRE_WRITE, CMD_PRE_QUERY, 8'h3C, ans);
      chk(ans, 10'h23C);
      cmd(CMD_SRQM_WRITE, 8'h40, 0);
      cmd(CMD_PRE_WRITE, 8'h00, 0);
      // Only the ignored mask bit set: no summary, no request
      drive(6'h3D);
      settle();
      chk(status(), 10'h0BC);
      $display("t_masks done");
   endtask

   task automatic t_bits();
      int pos [6] = '{2, 0, 3, 4, 5, 7};
      for (int i = 0; i < 6; i++) begin
         if (i != 1) begin
            drive(6'h01 << i);
            settle();
            chk(status(), {2'b00, 8'h01 << pos[i]});
         end
      end
      $display("t_bits done");
   endtask

   task automatic t_srq();
      cmd(CMD_SRQM_WRITE, 8'h48, 0);
      drive(6'h04);
      settle();
      chk(status(), 10'h248);
      u_sbs_ctrl_model.poll(ans);
      chk(ans, 10'h348);
      chk(status(), 10'h048);
      cmd(CMD_BYTE_QUERY, 8'h00, 2);
      chk(ans, 10'h248);
      drive(6'h00);
      settle();
      settle();
      chk(status(), 10'h000);
      $display("t_srq done");
   endtask

   task automatic t_ist();
      cmd(CMD_SRQM_WRITE, 8'h10, 0);
      cmd(CMD_PRE_WRITE, 8'h40, 0);
      drive(6'h08);
      settle();
      chk(status(), 10'h350);
      cmd(CMD_IST_QUERY, 8'h00, 0);
      chk(ans, 10'h201);
      cmd(CMD_PRE_WRITE, 8'h00, 0);
      chk(status(), 10'h250);
      cmd(CMD_IST_QUERY, 8'h00, 0);
      chk(ans, 10'h200);
      drive(6'h00);
      settle();
      settle();
      chk(status(), 10'h000);
      $display("t_ist done");
   endtask

   task automatic t_errq();
      cmd(CMD_SRQM_WRITE, 8'h04, 0);
      // Second pass: queue already nonempty, only the entry pulse
      repeat (2) begin
         drive(6'h03);
         drive(6'h01);
         #1;
         chk(status(), 10'h244);
         u_sbs_ctrl_model.poll(ans);
         chk(ans, 10'h344);
         chk(status(), 10'h044);
      end
      drive(6'h00);
      settle();
      settle();
      chk(status(), 10'h000);
      $display("t_errq done");
   endtask

   task automatic t_rereset();
      cmd(CMD_SRQM_WRITE, 8'h04, 0);
      drive(6'h01);
      settle();
      chk(status(), 10'h244);
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      #1;
      chk(status(), 10'h000);
      settle();
      chk(status(), 10'h004);
      cmd(CMD_SRQM_QUERY, 8'h00, 0);
      chk(ans, 10'h200);
      drive(6'h00);
      $display("t_rereset done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk_in);
      errors++;
      finish_test();
   end

   initial begin
      reset_in    = 1'b1;
      src         = 6'h00;
      errors      = 0;
      checks_done = 0;
      repeat (8) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      t_reset();
      t_masks();
      t_bits();
      t_srq();
      t_ist();
      t_errq();
      t_rereset();
      finish_test();
   end
endmodule

// [logic/sbs_mask_sum.sv]
`timescale 1ns/1ns
module sbs_mask_sum
   import sbs_pkg::*;
#(
   parameter int          W    = SBS_W,
   parameter logic [7:0]  KEEP = ALL_MASK
) (
   // Byte and mask
   input  wire logic [W-1:0] byte_in,
   input  wire logic [W-1:0] mask_in,
   // Summary
   output logic              sum_out
);

   // KEEP drops positions that must not take part in the sum
   assign sum_out = |(byte_in & mask_in & KEEP[W-1:0]);

endmodule

// [logic/sbs_pkg.sv]
package sbs_pkg;

   // Status byte geometry
   localparam int          SBS_W         = 8;
   localparam int          BIT_ERRQ      = 2;
   localparam int          BIT_QUES      = 3;
   localparam int          BIT_MSG_AVAIL = 4;
   localparam int          BIT_EVT_SUM   = 5;
   localparam int          BIT_MASTER    = 6;
   localparam int          BIT_OPER      = 7;
   localparam logic [7:0]  UNUSED_MASK   = 8'h03;
   localparam logic [7:0]  MASTER_MASK   = 8'h40;
   localparam logic [7:0]  NO_MASTER_MASK = 8'hBF;
   localparam logic [7:0]  ALL_MASK      = 8'hFF;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;

   // Mask reset values
   localparam logic [7:0]  SRQ_MASK_RESET  = 8'h00;
   localparam logic [7:0]  POLL_MASK_RESET = 8'h00;

   // Command codes on the command port
   typedef enum logic [2:0] {
      CMD_BYTE_QUERY = 3'h0,
      CMD_SRQM_WRITE = 3'h1,
      CMD_SRQM_QUERY = 3'h2,
      CMD_PRE_WRITE = 3'h3,
      CMD_PRE_QUERY = 3'h4,
      CMD_IST_QUERY = 3'h5
   } sbs_cmd_e;

   // Top-level state
   typedef struct packed {
      logic [7:0] status_byte;
      logic [7:0] srq_mask;
      logic [7:0] poll_mask;
      logic       srq;
      logic       ist;
      logic       rsp_valid;
      logic [7:0] rsp_data;
      logic       rsp_poll;
   } sbs_state_s;

endpackage

// [logic/sbs_rise_det.sv]
`timescale 1ns/1ns
module sbs_rise_det
   import sbs_pkg::*;
#(
   parameter int W = SBS_W
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         reset_in,
   // Watched byte and mask
   input  wire logic [W-1:0] byte_in,
   input  wire logic [W-1:0] mask_in,
   // Masked 0 to 1 transition, combinational
   output logic              rise_out
);

   typedef struct packed {
      logic [W-1:0] prev;
   } sbs_rise_s;

   sbs_rise_s cur_ff;
   sbs_rise_s nxt_cur;

   always_comb begin
      nxt_cur      = cur_ff;
      nxt_cur.prev = byte_in;
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Mask bit 6 never starts a request
   assign rise_out = |(byte_in & ~cur_ff.prev & mask_in
                       & NO_MASTER_MASK[W-1:0]);

endmodule

// [logic/sbs_status_top.sv]
`timescale 1ns/1ns
// Contract
// - Bit 6 summarises the other byte bits
// - Whole byte on query and serial poll
// - Each bit has mask bit, 6 ignored
// - Masked 0-to-1 transition raises service request
// - Service mask written and read back
// - Bit 2 set while error queue nonempty
// - Every new error entry requests service if mask bit 2 set
// - Bit 3 from questionable enabled events
// - Bit 4 while output message available
// - Bit 5 from enabled event status bits
// - Bit 6 set when masked bit set
// - Bit 7 from operation enabled events
// - Individual flag on parallel poll, query
// - Individual flag is OR of masked bits
// - Parallel poll mask written and read back
module sbs_status_top
   import sbs_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   // Summary sources from lower status logic
   input  wire logic       err_nonempty_in,
   input  wire logic       err_entry_in,
   input  wire logic       ques_sum_in,
   input  wire logic       message_available_flag_in,
   input  wire logic       event_summary_flag_in,
   input  wire logic       oper_sum_in,
   // Command port from the bus parser
   input  wire logic       cmd_valid_in,
   input  wire logic [2:0] cmd_code_in,
   input  wire logic [7:0] cmd_data_in,
   // Serial poll request
   input  wire logic       serial_poll_in,
   // Answers
   output logic            rsp_valid_out,
   output logic [7:0]      rsp_data_out,
   output logic            rsp_poll_out,
   // Bus status lines
   output logic            srq_out,
   output logic            ist_out,
   output logic [7:0]      summary_status_byte_out
);

   sbs_state_s cur_ff;
   sbs_state_s nxt_cur;

   logic [7:0] base_byte;
   logic [7:0] full_byte;
   logic [7:0] nxt_srq_mask;
   logic [7:0] nxt_poll_mask;
   logic       master_summary_flag;
   logic       ist_sum;
   logic       rise;
   logic       cmd_take;
   sbs_cmd_e   cmd_code;

   assign cmd_code = sbs_cmd_e'(cmd_code_in);
   // Serial poll has priority; a command in the same cycle is dropped
   assign cmd_take = cmd_valid_in & ~serial_poll_in;

   // Byte without the summary bit; bits 0 and 1 stay zero
   always_comb begin
      base_byte           = ZERO_BYTE;
      base_byte[BIT_ERRQ] = err_nonempty_in;
      base_byte[BIT_QUES] = ques_sum_in;
      base_byte[BIT_MSG_AVAIL] = message_available_flag_in;
      base_byte[BIT_EVT_SUM]   = event_summary_flag_in;
      base_byte[BIT_OPER] = oper_sum_in;
   end

   // Mask writes take effect on the byte of the same edge
   always_comb begin
      nxt_srq_mask  = cur_ff.srq_mask;
      nxt_poll_mask = cur_ff.poll_mask;
      if (cmd_take && cmd_code == CMD_SRQM_WRITE) begin
         nxt_srq_mask = cmd_data_in;
      end
      if (cmd_take && cmd_code == CMD_PRE_WRITE) begin
         nxt_poll_mask = cmd_data_in;
      end
   end

   sbs_mask_sum #(
      .W    (SBS_W),
      .KEEP (NO_MASTER_MASK)
   ) u_master (
      .byte_in (base_byte),
      .mask_in (nxt_srq_mask),
      .sum_out (master_summary_flag)
   );

   always_comb begin
      full_byte             = base_byte;
      full_byte[BIT_MASTER] = master_summary_flag;
   end

   // Bit 6 takes part in the individual flag
   sbs_mask_sum #(
      .W    (SBS_W),
      .KEEP (ALL_MASK)
   ) u_ist (
      .byte_in (full_byte),
      .mask_in (nxt_poll_mask),
      .sum_out (ist_sum)
   );

   sbs_rise_det #(
      .W (SBS_W)
   ) u_rise (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .byte_in    (base_byte),
      .mask_in    (nxt_srq_mask),
      .rise_out   (rise)
   );

   always_comb begin
      nxt_cur           = cur_ff;
      nxt_cur.status_byte = full_byte;
      nxt_cur.srq_mask    = nxt_srq_mask;
      nxt_cur.poll_mask   = nxt_poll_mask;
      nxt_cur.ist       = ist_sum;
      nxt_cur.rsp_valid = 1'b0;
      nxt_cur.rsp_poll  = 1'b0;
      // Request holds until polled or no enabled bit remains
      if (serial_poll_in || !master_summary_flag) begin
         nxt_cur.srq = 1'b0;
      end
      // Set wins over the poll clear in the same cycle
      if (rise) begin
         nxt_cur.srq = 1'b1;
      end
      // A new entry requests again even while bit 2 is already high
      if (err_entry_in && nxt_srq_mask[BIT_ERRQ]) begin
         nxt_cur.srq = 1'b1;
      end
      if (serial_poll_in) begin
         nxt_cur.rsp_valid = 1'b1;
         nxt_cur.rsp_poll  = 1'b1;
         nxt_cur.rsp_data  = cur_ff.status_byte;
      end else if (cmd_take) begin
         unique case (cmd_code)
            CMD_BYTE_QUERY: begin
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.rsp_data  = cur_ff.status_byte;
            end
            CMD_SRQM_QUERY: begin
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.rsp_data  = cur_ff.srq_mask;
            end
            CMD_PRE_QUERY: begin
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.rsp_data  = cur_ff.poll_mask;
            end
            CMD_IST_QUERY: begin
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.rsp_data  = {7'h00, cur_ff.ist};
            end
            CMD_SRQM_WRITE, CMD_PRE_WRITE: begin
               nxt_cur.rsp_valid = 1'b0;
            end
            // Unknown codes are ignored without an answer
            default: begin
               nxt_cur.rsp_valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cur_ff           <= '0;
         cur_ff.srq_mask  <= SRQ_MASK_RESET;
         cur_ff.poll_mask <= POLL_MASK_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign rsp_valid_out           = cur_ff.rsp_valid;
   assign rsp_data_out            = cur_ff.rsp_data;
   assign rsp_poll_out            = cur_ff.rsp_poll;
   assign srq_out                 = cur_ff.srq;
   assign ist_out                 = cur_ff.ist;
   assign summary_status_byte_out = cur_ff.status_byte;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);

   a_unused_bits_zero: assert property (
      (cur_ff.status_byte & UNUSED_MASK) == ZERO_BYTE)
      else $error("status byte bits 0 and 1 not zero");

   a_master_is_sum: assert property (
      cur_ff.status_byte[BIT_MASTER]
         == |(cur_ff.status_byte & cur_ff.srq_mask & NO_MASTER_MASK))
      else $error("summary bit does not match masked byte");

   a_master_srq_active: assert property (
      srq_out |-> cur_ff.status_byte[BIT_MASTER])
      else $error("service request without summary bit");

   a_errq_tracks: assert property (
      err_nonempty_in |=> cur_ff.status_byte[BIT_ERRQ])
      else $error("error queue bit not set");

   a_ques_tracks: assert property (
      ques_sum_in |=> cur_ff.status_byte[BIT_QUES])
      else $error("questionable bit not set");

   a_msg_avail_tracks: assert property (
      message_available_flag_in |=> cur_ff.status_byte[BIT_MSG_AVAIL])
      else $error("message available bit not set");

   a_evt_sum_tracks: assert property (
      event_summary_flag_in |=> cur_ff.status_byte[BIT_EVT_SUM])
      else $error("event summary bit not set");

   a_oper_tracks: assert property (
      !oper_sum_in |=> !cur_ff.status_byte[BIT_OPER])
      else $error("operation bit set without source");

   a_srq_on_rise: assert property (
      |(cur_ff.status_byte & ~$past(cur_ff.status_byte)
        & cur_ff.srq_mask & NO_MASTER_MASK)
      |-> srq_out)
      else $error("no service request on masked rise");

   // Poll clear only holds when no new set arrives in the same cycle
   a_poll_clears_srq: assert property (
      serial_poll_in && !rise && !(err_entry_in && nxt_srq_mask[BIT_ERRQ])
      |=> !srq_out)
      else $error("service request not cleared by poll");

   a_srq_err_entry: assert property (
      err_entry_in && nxt_srq_mask[BIT_ERRQ] |=> srq_out)
      else $error("error entry did not request service");

   a_poll_answer: assert property (
      serial_poll_in |=> rsp_valid_out && rsp_poll_out
         && rsp_data_out == $past(cur_ff.status_byte))
      else $error("serial poll answer wrong");

   a_byte_query: assert property (
      cmd_take && cmd_code == CMD_BYTE_QUERY |=> rsp_valid_out
         && !rsp_poll_out && rsp_data_out == $past(cur_ff.status_byte))
      else $error("status byte query answer wrong");

   a_poll_flag_pairs: assert property (
      rsp_poll_out |-> rsp_valid_out)
      else $error("poll flag without answer");

   // Codes 6 and 7 are spare; answering them would confuse the parser
   a_unknown_silent: assert property (
      cmd_take && cmd_code_in > CMD_IST_QUERY |=> !rsp_valid_out)
      else $error("unknown code produced an answer");

   a_write_silent: assert property (
      cmd_take && (cmd_code == CMD_SRQM_WRITE || cmd_code == CMD_PRE_WRITE)
      |=> !rsp_valid_out)
      else $error("mask write produced an answer");

   // A command beside a serial poll is lost, mask must not move
   a_poll_drops_cmd: assert property (
      serial_poll_in && cmd_valid_in && cmd_code == CMD_SRQM_WRITE
      |=> cur_ff.srq_mask == $past(cur_ff.srq_mask))
      else $error("command taken during serial poll");

   a_srq_mask_readback: assert property (
      cmd_take && cmd_code == CMD_SRQM_WRITE
      ##1 cmd_take && cmd_code == CMD_SRQM_QUERY
      |=> rsp_valid_out && rsp_data_out == $past(cmd_data_in, 2))
      else $error("service mask read back wrong");

   a_pre_readback: assert property (
      cmd_take && cmd_code == CMD_PRE_WRITE
      ##1 cmd_take && cmd_code == CMD_PRE_QUERY
      |=> rsp_valid_out && rsp_data_out == $past(cmd_data_in, 2))
      else $error("parallel poll mask read back wrong");

   a_ist_formed: assert property (
      ist_out == |(cur_ff.status_byte & cur_ff.poll_mask))
      else $error("individual flag not masked OR");

   a_ist_uses_master: assert property (
      cur_ff.poll_mask[BIT_MASTER] && cur_ff.status_byte[BIT_MASTER]
      |-> ist_out)
      else $error("summary bit ignored by individual flag");

   a_ist_answer: assert property (
      cmd_take && cmd_code == CMD_IST_QUERY
      |=> rsp_valid_out && rsp_data_out == {7'h00, $past(ist_out)})
      else $error("individual flag query answer wrong");

   c_srq_raised: cover property ($rose(srq_out));
   c_poll_clears: cover property (srq_out && serial_poll_in ##1 !srq_out);
   c_ist_raised: cover property ($rose(ist_out));
   c_err_repeat: cover property (
      srq_out && err_entry_in ##1 srq_out && cur_ff.status_byte[BIT_ERRQ]);
   c_write_then_read: cover property (
      cmd_take && cmd_code == CMD_SRQM_WRITE
      ##1 cmd_take && cmd_code == CMD_SRQM_QUERY);

endmodule
